// File: rtl/core_stack_and_boot_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// - stack lives in shared SRAM, starting at its top
// - call, return, interrupt entry use stack automatically
// - explicit push, pop and interrupt pop supported
// - reset sets stack top to SRAM top
// - push decrements stack top pointer
// - pop increments stack top pointer
// - utility ROM of 1.5KB at 8000h
// - fetch starts at 8000h after any reset
// - boot jumps to 0000h unless test mode
// - separate 16-bit program and data buses
module core_stack_and_boot_sequencer #(
    parameter int BOOT_LEN = core_stack_pkg::BOOT_CYCLES,
    parameter int RAM_WORDS = core_stack_pkg::SRAM_WORDS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // test mode request from the debug port, asynchronous
    input wire logic testModePin,
    // stack operation request
    input wire logic opValid,
    input wire core_stack_pkg::stack_op_e opCode,
    input wire logic [15:0] opData,
    // application data port into the shared SRAM
    input wire logic appReq,
    input wire logic appWe,
    input wire logic [15:0] appAddr,
    input wire logic [15:0] appWrData,
    // program side
    output logic [15:0] fetchAddr,
    output logic opReady,
    output logic testMode,
    output logic intActive,
    // stack side
    output logic [15:0] stackTopPointer,
    output logic [15:0] popData,
    output logic popValid,
    // application answers
    output logic appAck,
    output logic appRdValid,
    output logic [15:0] appRdData
);

    localparam int AW = core_stack_pkg::SRAM_ADDR_W;

    // the test request needs two synchroniser edges after reset to be seen
    if (BOOT_LEN < 3 || BOOT_LEN > 255 ||
        BOOT_LEN > core_stack_pkg::ROM_WORDS)
    begin : gBadBoot
        $error("BOOT_LEN out of range");
    end
    if (RAM_WORDS != (1 << AW))
    begin : gBadRam
        $error("RAM_WORDS must match the SRAM address width");
    end

    localparam logic [7:0] BOOT_LAST = 8'(BOOT_LEN - 1);

    core_stack_pkg::seq_s stateReg;
    core_stack_pkg::seq_s stateNext;
    logic stackUse;
    logic opTaken;

    stack_ram_if #(.ADDR_W(AW), .DATA_W(16)) ram ();

    stack_ram #(
        .WORDS(RAM_WORDS)
    ) u_ram (
        .clk(clk),
        .sys_rst(sys_rst),
        .port(ram.mem)
    );

    assign opTaken = opValid && stateReg.opReady &&
        (opCode != core_stack_pkg::OP_NONE);

    always_comb
    begin
        stateNext = stateReg;
        stackUse = 1'b0;
        ram.en = 1'b0;
        ram.we = 1'b0;
        ram.addr = stateReg.stackTop[AW-1:0];
        ram.wdata = opData;
        stateNext.popValid = 1'b0;
        stateNext.appAck = 1'b0;
        stateNext.appRdValid = stateReg.appRdPend;
        stateNext.appRdPend = 1'b0;
        stateNext.testSync = {stateReg.testSync[0], testModePin};
        unique case (stateReg.state)
            core_stack_pkg::ST_BOOT:
            begin
                // utility ROM runs from its base, then hands over
                stateNext.fetchAddr = stateReg.fetchAddr +
                    core_stack_pkg::WORD_STEP;
                stateNext.bootCnt = stateReg.bootCnt +
                    core_stack_pkg::BOOT_CNT_STEP;
                if (stateReg.bootCnt == BOOT_LAST)
                begin
                    if (stateReg.testSync[1])
                    begin
                        stateNext.state = core_stack_pkg::ST_TEST;
                        stateNext.testMode = 1'b1;
                        stateNext.fetchAddr = stateReg.fetchAddr;
                    end
                    else
                    begin
                        stateNext.state = core_stack_pkg::ST_RUN;
                        // hand over to user code
                        stateNext.fetchAddr =
                            core_stack_pkg::USER_START;
                    end
                end
            end
            core_stack_pkg::ST_TEST:
            begin
                // test code stays in ROM until the next reset
                stateNext.fetchAddr = stateReg.fetchAddr;
            end
            core_stack_pkg::ST_RUN:
            begin
                stateNext.fetchAddr = stateReg.fetchAddr +
                    core_stack_pkg::WORD_STEP;
                if (opTaken)
                begin
                    stackUse = 1'b1;
                    ram.en = 1'b1;
                    unique case (opCode)
                        core_stack_pkg::OP_PUSH,
                        core_stack_pkg::OP_CALL,
                        core_stack_pkg::OP_INT_ENTRY:
                        begin
                            // write at the top, then move down a word
                            ram.we = 1'b1;
                            stateNext.stackTop = stateReg.stackTop -
                                core_stack_pkg::WORD_STEP;
                            if (opCode == core_stack_pkg::OP_CALL)
                            begin
                                ram.wdata = stateReg.fetchAddr +
                                    core_stack_pkg::WORD_STEP;
                                stateNext.fetchAddr = opData;
                            end
                            else if (opCode ==
                                core_stack_pkg::OP_INT_ENTRY)
                            begin
                                // the interrupted fetch is resumed later
                                ram.wdata = stateReg.fetchAddr;
                                stateNext.fetchAddr = opData;
                                stateNext.intActive = 1'b1;
                            end
                        end
                        default:
                        begin
                            // all pop kinds: move up a word, then read
                            stateNext.stackTop = stateReg.stackTop +
                                core_stack_pkg::WORD_STEP;
                            ram.addr = stateNext.stackTop[AW-1:0];
                            stateNext.state = core_stack_pkg::ST_POPWAIT;
                            stateNext.pendOp = opCode;
                            stateNext.fetchAddr = stateReg.fetchAddr;
                        end
                    endcase
                end
            end
            core_stack_pkg::ST_POPWAIT:
            begin
                stateNext.state = core_stack_pkg::ST_RUN;
                unique case (stateReg.pendOp)
                    core_stack_pkg::OP_RET,
                    core_stack_pkg::OP_RETURN_FROM_INTERRUPT:
                    begin
                        stateNext.fetchAddr = ram.rdata;
                    end
                    default:
                    begin
                        stateNext.fetchAddr = stateReg.fetchAddr +
                            core_stack_pkg::WORD_STEP;
                        stateNext.popData = ram.rdata;
                        stateNext.popValid = 1'b1;
                    end
                endcase
                if (stateReg.pendOp ==
                        core_stack_pkg::OP_RETURN_FROM_INTERRUPT ||
                    stateReg.pendOp == core_stack_pkg::OP_INTERRUPT_POP)
                begin
                    stateNext.intActive = 1'b0;
                end
            end
        endcase
        // application shares the SRAM; the stack has priority
        if (appReq && !stackUse)
        begin
            ram.en = 1'b1;
            ram.we = appWe;
            ram.addr = appAddr[AW-1:0];
            ram.wdata = appWrData;
            stateNext.appAck = 1'b1;
            stateNext.appRdPend = !appWe;
        end
        stateNext.opReady = (stateNext.state == core_stack_pkg::ST_RUN);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stateReg.state <= core_stack_pkg::ST_BOOT;
            stateReg.pendOp <= core_stack_pkg::OP_NONE;
            stateReg.fetchAddr <= core_stack_pkg::ROM_BASE;
            stateReg.stackTop <= core_stack_pkg::SRAM_TOP;
            stateReg.bootCnt <= core_stack_pkg::BOOT_CNT_RESET;
            stateReg.testSync <= 2'h0;
            stateReg.testMode <= 1'b0;
            stateReg.opReady <= 1'b0;
            stateReg.popData <= core_stack_pkg::DATA_RESET;
            stateReg.popValid <= 1'b0;
            stateReg.intActive <= 1'b0;
            stateReg.appAck <= 1'b0;
            stateReg.appRdValid <= 1'b0;
            stateReg.appRdPend <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    // separate program and data paths, both a word wide
    assign fetchAddr = stateReg.fetchAddr;
    assign stackTopPointer = stateReg.stackTop;
    assign opReady = stateReg.opReady;
    assign testMode = stateReg.testMode;
    assign intActive = stateReg.intActive;
    assign popData = stateReg.popData;
    assign popValid = stateReg.popValid;
    assign appAck = stateReg.appAck;
    assign appRdValid = stateReg.appRdValid;
    assign appRdData = ram.rdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic isPush;
    logic isPop;
    logic isRet;
    assign isPush = opTaken && (opCode == core_stack_pkg::OP_PUSH ||
        opCode == core_stack_pkg::OP_CALL ||
        opCode == core_stack_pkg::OP_INT_ENTRY);
    assign isPop = opTaken && (opCode == core_stack_pkg::OP_POP ||
        opCode == core_stack_pkg::OP_INTERRUPT_POP);
    assign isRet = opTaken && (opCode == core_stack_pkg::OP_RET ||
        opCode == core_stack_pkg::OP_RETURN_FROM_INTERRUPT);

    sequence bootEnd;
        stateReg.state == core_stack_pkg::ST_BOOT &&
            stateReg.bootCnt == BOOT_LAST && !stateReg.testSync[1];
    endsequence

    sequence retIssue;
        isRet ##1 stateReg.state == core_stack_pkg::ST_POPWAIT;
    endsequence

    resetTop_a: assert property ($fell(sys_rst) |->
        stackTopPointer == core_stack_pkg::SRAM_TOP)
        else $error("stack top not at SRAM top after reset");

    resetFetch_a: assert property ($fell(sys_rst) |->
        fetchAddr == core_stack_pkg::ROM_BASE)
        else $error("fetch did not start in utility ROM");

    romRange_a: assert property (
        stateReg.state == core_stack_pkg::ST_BOOT |->
        fetchAddr >= core_stack_pkg::ROM_BASE &&
        fetchAddr <= core_stack_pkg::ROM_LAST)
        else $error("boot fetch left the utility ROM");

    bootJump_a: assert property (bootEnd |=>
        fetchAddr == core_stack_pkg::USER_START &&
        stateReg.state == core_stack_pkg::ST_RUN)
        else $error("boot did not hand over to user code");

    pushDown_a: assert property (isPush |=>
        stackTopPointer == $past(stackTopPointer) -
        core_stack_pkg::WORD_STEP)
        else $error("push did not lower the stack top by one word");

    popUp_a: assert property ((isPop || isRet) |=>
        stackTopPointer == $past(stackTopPointer) +
        core_stack_pkg::WORD_STEP)
        else $error("pop did not raise the stack top by one word");

    stackWrite_a: assert property (isPush |->
        ram.en && ram.we && ram.addr == stackTopPointer[AW-1:0])
        else $error("push did not write at the stack top");

    callJump_a: assert property (
        (opTaken && opCode == core_stack_pkg::OP_CALL) |->
        ram.wdata == fetchAddr + core_stack_pkg::WORD_STEP ##1
        fetchAddr == $past(opData))
        else $error("call did not save return and jump");

    retLoad_a: assert property (retIssue |=>
        fetchAddr == $past(ram.rdata))
        else $error("return did not restore the fetch address");

    popAnswer_a: assert property (isPop |->
        ##1 !popValid ##1 popValid && popData == $past(ram.rdata))
        else $error("pop data not delivered two cycles later");

endmodule // core_stack_and_boot_sequencer

// File: rtl/core_stack_pkg.sv
package core_stack_pkg;

    // core bus widths
    localparam int WORD_W = 16;
    localparam logic [15:0] WORD_STEP = 16'h0001;

    // utility ROM in program space
    localparam logic [15:0] ROM_BASE = 16'h8000;
    localparam int ROM_WORDS = 768;
    localparam logic [15:0] ROM_LAST = 16'h82FF;

    // user application entry point
    localparam logic [15:0] USER_START = 16'h0000;

    // data SRAM, 2KB as 16-bit words
    localparam int SRAM_WORDS = 1024;
    localparam int SRAM_ADDR_W = 10;
    localparam logic [15:0] SRAM_TOP = 16'h03FF;

    // run length of the utility ROM before it hands over
    localparam int BOOT_CYCLES = 8;
    localparam int BOOT_CNT_W = 8;
    localparam logic [7:0] BOOT_CNT_RESET = 8'h00;
    localparam logic [7:0] BOOT_CNT_STEP = 8'h01;

    localparam logic [15:0] DATA_RESET = 16'h0000;

    typedef enum logic [2:0] {
        OP_NONE                    = 3'b000,
        OP_PUSH                    = 3'b001,
        OP_POP                     = 3'b010,
        OP_CALL                    = 3'b011,
        OP_RET                     = 3'b100,
        OP_RETURN_FROM_INTERRUPT   = 3'b101,
        OP_INT_ENTRY               = 3'b110,
        OP_INTERRUPT_POP           = 3'b111
    } stack_op_e;

    typedef enum logic [1:0] {
        ST_BOOT    = 2'b00,
        ST_TEST    = 2'b01,
        ST_RUN     = 2'b10,
        ST_POPWAIT = 2'b11
    } seq_state_e;

    typedef struct packed {
        seq_state_e state;
        stack_op_e pendOp;
        logic [15:0] fetchAddr;
        logic [15:0] stackTop;
        logic [7:0] bootCnt;
        logic [1:0] testSync;
        logic testMode;
        logic opReady;
        logic [15:0] popData;
        logic popValid;
        logic intActive;
        logic appAck;
        logic appRdValid;
        logic appRdPend;
    } seq_s;

endpackage

// File: rtl/stack_ram.sv
`timescale 1ns/100ps
module stack_ram #(
    parameter int WORDS = 1024
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // memory port
    stack_ram_if.mem port
);

    // rdata holds between reads so a late consumer still sees it
    logic [15:0] mem [WORDS];

    always_ff @(posedge clk)
    begin
        if (port.en && port.we)
        begin
            mem[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port.rdata <= core_stack_pkg::DATA_RESET;
        end
        else if (port.en && !port.we)
        begin
            port.rdata <= mem[port.addr];
        end
    end

endmodule // stack_ram

// File: rtl/stack_ram_if.sv
`timescale 1ns/100ps
interface stack_ram_if #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 16
);
    logic en;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem (input en, input we, input addr, input wdata,
                 output rdata);
endinterface

// File: tb/core_stack_and_boot_sequencer_tb_top.sv
`timescale 1ns/100ps
module core_stack_and_boot_sequencer_tb_top;
    // short boot keeps the run brief; expectations use the same value
    localparam int BL = 4;
    typedef struct packed {
        core_stack_pkg::stack_op_e op;
        logic [15:0] data;
        logic [15:0] expTop;
    } row_s;
    logic clk;
    logic sys_rst;
    logic testModePin;
    logic opValid;
    core_stack_pkg::stack_op_e opCode;
    logic [15:0] opData;
    logic appReq;
    logic appWe;
    logic [15:0] appAddr;
    logic [15:0] appWrData;
    logic [15:0] fetchAddr;
    logic opReady;
    logic testMode;
    logic intActive;
    logic [15:0] stackTopPointer;
    logic [15:0] popData;
    logic popValid;
    logic appAck;
    logic appRdValid;
    logic [15:0] appRdData;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] model[$];
    logic [15:0] rd;
    row_s rows[10];

    core_stack_and_boot_sequencer #(.BOOT_LEN(BL))
    i_core_stack_and_boot_sequencer (
        .clk(clk), .sys_rst(sys_rst), .testModePin(testModePin),
        .opValid(opValid), .opCode(opCode), .opData(opData),
        .appReq(appReq), .appWe(appWe), .appAddr(appAddr),
        .appWrData(appWrData), .fetchAddr(fetchAddr), .opReady(opReady),
        .testMode(testMode), .intActive(intActive),
        .stackTopPointer(stackTopPointer), .popData(popData),
        .popValid(popValid), .appAck(appAck), .appRdValid(appRdValid),
        .appRdData(appRdData)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic in_rom();
        return fetchAddr >= core_stack_pkg::ROM_BASE &&
            fetchAddr <= core_stack_pkg::ROM_LAST;
    endfunction

    task automatic do_reset(input logic tm);
        @(negedge clk);
        sys_rst = 1'b1;
        testModePin = tm;
        repeat (5) @(negedge clk);
        chk(fetchAddr, core_stack_pkg::ROM_BASE);
        chk(stackTopPointer, core_stack_pkg::SRAM_TOP);
        chk(opReady, 16'h0000);
        sys_rst = 1'b0;
        model.delete();
    endtask

    // boot must stay in ROM, then hand over to the user entry point
    task automatic boot_ok();
        int n;
        n = 0;
        while (opReady !== 1'b1 && n < BL + 8)
        begin
            chk(in_rom(), 16'h0001);
            @(negedge clk);
            n++;
        end
        chk(fetchAddr, core_stack_pkg::USER_START);
        chk(n >= BL - 1 && n <= BL + 3, 16'h0001);
    endtask

    task automatic do_op(input core_stack_pkg::stack_op_e op,
                         input logic [15:0] d, input logic [15:0] expTop);
        logic [15:0] fa;
        logic [15:0] v;
        int n;
        n = 0;
        while (opReady !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        fa = fetchAddr;
        opValid = 1'b1;
        opCode = op;
        opData = d;
        @(negedge clk);
        opValid = 1'b0;
        opCode = core_stack_pkg::OP_NONE;
        chk(stackTopPointer, expTop);
        case (op)
            core_stack_pkg::OP_PUSH: model.push_front(d);
            core_stack_pkg::OP_CALL:
            begin
                model.push_front(fa + 16'h0001);
                chk(fetchAddr, d);
            end
            core_stack_pkg::OP_INT_ENTRY:
            begin
                model.push_front(fa);
                chk(fetchAddr, d);
                chk(intActive, 16'h0001);
            end
            default:
            begin
                v = model.pop_front();
                chk(opReady, 16'h0000);
                @(negedge clk);
                if (op inside {core_stack_pkg::OP_POP,
                               core_stack_pkg::OP_INTERRUPT_POP})
                begin
                    chk(popValid, 16'h0001);
                    chk(popData, v);
                end
                else
                    chk(fetchAddr, v);
                if (op != core_stack_pkg::OP_POP &&
                    op != core_stack_pkg::OP_RET)
                    chk(intActive, 16'h0000);
            end
        endcase
    endtask

    task automatic app(input logic we, input logic [15:0] a,
                       input logic [15:0] w, output logic [15:0] r);
        int n;
        appReq = 1'b1;
        appWe = we;
        appAddr = a;
        appWrData = w;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (appAck !== 1'b1 && n < 8);
        appReq = 1'b0;
        appWe = 1'b0;
        chk(appAck, 16'h0001);
        n = 0;
        while (!we && appRdValid !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        if (!we)
            chk(appRdValid, 16'h0001);
        r = appRdData;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            stop_test();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        testModePin = 1'b0;
        opValid = 1'b0;
        opCode = core_stack_pkg::OP_NONE;
        opData = 16'h0000;
        appReq = 1'b0;
        appWe = 1'b0;
        appAddr = 16'h0000;
        appWrData = 16'h0000;
        rows = '{
            '{core_stack_pkg::OP_PUSH, 16'h1234, 16'h03FE},
            '{core_stack_pkg::OP_PUSH, 16'hABCD, 16'h03FD},
            '{core_stack_pkg::OP_POP, 16'h0000, 16'h03FE},
            '{core_stack_pkg::OP_CALL, 16'h0040, 16'h03FD},
            '{core_stack_pkg::OP_INT_ENTRY, 16'h0100, 16'h03FC},
            '{core_stack_pkg::OP_RETURN_FROM_INTERRUPT, 16'h0000, 16'h03FD},
            '{core_stack_pkg::OP_RET, 16'h0000, 16'h03FE},
            '{core_stack_pkg::OP_INT_ENTRY, 16'h0200, 16'h03FD},
            '{core_stack_pkg::OP_INTERRUPT_POP, 16'h0000, 16'h03FE},
            '{core_stack_pkg::OP_POP, 16'h0000, 16'h03FF}};
        do_reset(1'b0);
        boot_ok();
        foreach (rows[i])
            do_op(rows[i].op, rows[i].data, rows[i].expTop);
        // stack words are plain SRAM words seen by the application port
        do_op(core_stack_pkg::OP_PUSH, 16'h5A5A, 16'h03FE);
        app(1'b0, 16'h03FF, 16'h0000, rd);
        chk(rd, 16'h5A5A);
        app(1'b1, 16'h03FF, 16'hC3C3, rd);
        model[0] = 16'hC3C3;
        do_op(core_stack_pkg::OP_POP, 16'h0000, 16'h03FF);
        // a push offered while a pop settles is dropped
        do_op(core_stack_pkg::OP_PUSH, 16'h1111, 16'h03FE);
        opValid = 1'b1;
        opCode = core_stack_pkg::OP_POP;
        @(negedge clk);
        opCode = core_stack_pkg::OP_PUSH;
        opData = 16'h2222;
        @(negedge clk);
        opValid = 1'b0;
        chk(stackTopPointer, 16'h03FF);
        chk(popData, 16'h1111);
        void'(model.pop_front());
        // stack wins the shared SRAM; the application retries
        appReq = 1'b1;
        appAddr = 16'h03FF;
        opValid = 1'b1;
        opCode = core_stack_pkg::OP_PUSH;
        opData = 16'h7777;
        @(negedge clk);
        opValid = 1'b0;
        chk(appAck, 16'h0000);
        model.push_front(16'h7777);
        app(1'b0, 16'h03FF, 16'h0000, rd);
        chk(rd, 16'h7777);
        do_op(core_stack_pkg::OP_POP, 16'h0000, 16'h03FF);
        // test mode keeps the core parked in ROM
        do_reset(1'b1);
        repeat (BL + 8) @(negedge clk);
        chk(testMode, 16'h0001);
        chk(opReady, 16'h0000);
        chk(in_rom(), 16'h0001);
        do_reset(1'b0);
        boot_ok();
        chk(testMode, 16'h0000);
        do_op(core_stack_pkg::OP_PUSH, 16'hFFFF, 16'h03FE);
        stop_test();
    end
endmodule // core_stack_and_boot_sequencer_tb_top
